// *** core/eqr_pkg.sv ***
/*
  Package for the error queue and nonvolatile restore command block.
  Holds register offsets, command codes, selectors, defaults and field
  positions. Assumes an APB slave with 32-bit data, one word per register.
*/
package eqr_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CMD = 8'h00;       // Command code and argument
  localparam logic [7:0] OFF_RESP = 8'h04;      // Reply word of last command
  localparam logic [7:0] OFF_STAT = 8'h08;      // Sticky event status
  localparam logic [7:0] OFF_MASK = 8'h0c;      // Interrupt mask
  localparam logic [7:0] OFF_ERRIN = 8'h10;     // Error report from system
  localparam logic [7:0] OFF_ACTIVE_FUNCTION_QUERY = 8'h14;      // Active function select
  localparam logic [7:0] OFF_SERIAL = 8'h18;    // Serial port settings
  localparam logic [7:0] OFF_NVSTAT = 8'h1c;    // Restore state flags
  localparam logic [7:0] OFF_INFO = 8'h20;      // Queue level and busy
  localparam logic [7:0] OFF_TEXT = 8'h24;      // Explain-text word index

  // ----------------------------------------------------------------
  // Command codes, written in bits 3:0 of the command register
  // ----------------------------------------------------------------
  typedef enum logic [3:0]
  {
    CMD_NONE = 4'h0,
    CMD_POP = 4'h1,           // Pop oldest code
    CMD_EXPLAIN = 4'h2,       // Explain a code
    CMD_POP_EXPLAIN = 4'h3,   // Pop oldest code plus its text
    CMD_RESTORE = 4'h4,       // Restore nonvolatile contents
    CMD_ACTIVE_FUNCTION_QUERY = 4'h5           // Active function query
  } eqr_cmd_type;

  // Restore selectors, bits 9:8 of the command register
  localparam logic [1:0] SEL_ALL = 2'h0;
  localparam logic [1:0] SEL_CAL = 2'h1;
  localparam logic [1:0] SEL_SETUP = 2'h2;

  // Command register fields
  localparam int CMD_LSB = 0;
  localparam int SEL_LSB = 8;
  localparam int ARG_LSB = 16;

  // Error report register: bit 16 marks a system error
  localparam int ERR_SYS_BIT = 16;

  // Status bits
  localparam int ST_DONE = 0;       // Command finished
  localparam int ST_EXEC_ERR = 1;   // Execution error
  localparam int ST_QUEUED = 2;     // System error queued
  localparam int ST_OVERFLOW = 3;   // Queue full, entry dropped
  localparam int ST_TERM_MSG = 4;   // Error sent at once in terminal mode
  localparam int ST_WIDTH = 5;

  // Serial field layout and factory values
  localparam logic [3:0] SER_DATA_BITS = 4'h8;
  localparam logic [1:0] SER_STOP_BITS = 2'h1;
  localparam logic [1:0] SER_FLOW_XON = 2'h1;
  localparam logic [1:0] SER_PARITY_NONE = 2'h0;
  localparam logic [15:0] SER_BAUD = 16'h2580;    // 9600
  localparam logic [5:0] SER_WAIT_S = 6'h1e;      // 30 seconds
  localparam logic [31:0] SER_DEFAULT =
    {SER_WAIT_S, SER_BAUD, SER_PARITY_NONE, SER_FLOW_XON,
     SER_STOP_BITS, SER_DATA_BITS};

  // Restore state flag bits
  localparam int NV_CAL_DEF = 0;    // Calibration at factory defaults
  localparam int NV_SETUP_DEF = 1;  // Setup at factory defaults
  localparam int NV_PUD_CLR = 2;    // User power-up string cleared
  localparam int NV_SRQ_DEF = 3;    // Service-request template default
  localparam int NV_SPL_DEF = 4;    // Serial-poll template default
  localparam int NV_TERM = 5;       // Remote interface in terminal mode

  // Function mnemonic codes, index into the reply text table
  localparam int ACTIVE_FUNCTION_QUERY_DUAL_DCV = 10;
  localparam logic [4:0] ACTIVE_FUNCTION_QUERY_RESET = 5'h00;

  // Empty queue reply
  localparam logic [15:0] NO_ERROR = 16'h0000;

  // Text character codes for the variable markers
  localparam logic [7:0] CH_PCT = 8'h25;
  localparam logic [7:0] CH_D = 8'h64;
  localparam logic [7:0] CH_F = 8'h66;
  localparam logic [7:0] CH_S = 8'h73;

endpackage : eqr_pkg

// *** core/eqr_fifo_mem.sv ***
/*
  Small memory holding the queued error codes.
  Assumes a single clock; read data comes out of a register.
*/
`timescale 1ns/100ps
`default_nettype none

module eqr_fifo_mem
#(
  parameter int WIDTH = 16,
  parameter int AW = 3
)
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  // Storage array, no reset needed for data
  logic [WIDTH-1:0] mem_reg [0:(1<<AW)-1];

  // -------------------------------------------------------
  // Write port and registered read port
  // -------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_reg[wr_addr] <= wr_data;
    end
    rd_data <= mem_reg[rd_addr];
  end

endmodule : eqr_fifo_mem
`default_nettype wire

// *** core/eqr_text_rom.sv ***
/*
  Text table for explanation replies and function mnemonics.
  Each entry is one 32-bit word of four characters, looked up by code.
  Assumes a single clock; output is registered.
*/
`timescale 1ns/100ps
`default_nettype none

module eqr_text_rom
(
  input wire logic clk,
  input wire logic [15:0] code,
  input wire logic [1:0] word_idx,
  output logic [31:0] text
);

  // Combinational lookup, keeps the table readable
  logic [31:0] text_next;

  // -------------------------------------------------------
  // Table: codes 0x000-0x0ff errors, 0x100+ function names
  // -------------------------------------------------------
  always_comb
  begin
    text_next = 32'h3f3f3f3f;  // Unknown code reads as question marks
    case ({code, word_idx})
      {16'h0000, 2'h0}: text_next = 32'h4e6f2045;  // "No E"
      {16'h0000, 2'h1}: text_next = 32'h72726f72;  // "rror"
      {16'h0001, 2'h0}: text_next = 32'h42616420;  // "Bad "
      {16'h0001, 2'h1}: text_next = {eqr_pkg::CH_PCT, eqr_pkg::CH_D,
                                     16'h2020};    // Integer variable
      {16'h0002, 2'h0}: text_next = 32'h4c696d20;  // "Lim "
      {16'h0002, 2'h1}: text_next = {eqr_pkg::CH_PCT, eqr_pkg::CH_F,
                                     16'h2020};    // Float variable
      {16'h0003, 2'h0}: text_next = 32'h4e616d20;  // "Nam "
      {16'h0003, 2'h1}: text_next = {eqr_pkg::CH_PCT, eqr_pkg::CH_S,
                                     16'h2020};    // String variable
      {16'h0004, 2'h0}: text_next = 32'h4e6f2063;  // "No c"
      {16'h0004, 2'h1}: text_next = 32'h616c2021;  // "al !"
      {16'h0100, 2'h0}: text_next = 32'h44435620;  // "DCV "
      {16'h0101, 2'h0}: text_next = 32'h41435620;  // "ACV "
      {16'h0102, 2'h0}: text_next = 32'h44434920;  // "DCI "
      {16'h0103, 2'h0}: text_next = 32'h41434920;  // "ACI "
      {16'h010a, 2'h0}: text_next = 32'h44434444;  // Dual dc volts
      default: text_next = 32'h3f3f3f3f;
    endcase
  end

  // Registered output
  always_ff @(posedge clk)
  begin
    text <= text_next;
  end

endmodule : eqr_text_rom
`default_nettype wire

// *** core/eqr_core.sv ***
/*
  Error queue, error explanation, nonvolatile restore and function query
  command block, reached over APB.
  Assumes one 50 MHz clock, synchronous active-high reset, and that the
  calibration-protect switch and terminal-mode level come from pins.
*/
// What this block does
// - Explain query returns text for code
// - Variables shown as percent plus d/f/s
// - Outside terminal mode, pop returns oldest code, then removes
// - Empty queue pop returns zero
// - Only system errors enter the queue
// - Restore overwrites store with factory defaults
// - Restore refused unless switch enabled, setup exempt
// - Selectors all, cal, setup reset own part
// - All equals cal then setup
// - Setup clears power-up string, sets templates
// - Setup sets serial defaults 8N1 9600 30s
// - Function query returns active function mnemonic
// - Combined query returns code and text
// - Terminal mode sends errors, never queues
`timescale 1ns/100ps
`default_nettype none

module eqr_core
#(
  parameter int DEPTH_LOG2 = 3,   // Queue holds 2**DEPTH_LOG2 codes
  parameter int CODE_W = 16
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cal_enable_pin,
  input wire logic term_mode_pin,
  output logic irq
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] cal_sync_reg;     // Switch, two stages
  logic [1:0] term_sync_reg;    // Terminal mode, two stages
  wire cal_ok = cal_sync_reg[1];
  wire term_mode = term_sync_reg[1];

  always_ff @(posedge clk)
  begin
    cal_sync_reg <= {cal_sync_reg[0], cal_enable_pin};
    term_sync_reg <= {term_sync_reg[0], term_mode_pin};
  end

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b10,
    ST_FIN = 2'b11
  } eqr_state_type;

  eqr_state_type state_reg;
  wire acc = psel && penable;
  wire wr_acc = acc && pwrite;
  wire rd_acc = acc && !pwrite;
  wire hit_cmd = paddr == eqr_pkg::OFF_CMD;
  wire hit_resp = paddr == eqr_pkg::OFF_RESP;
  wire hit_stat = paddr == eqr_pkg::OFF_STAT;
  wire hit_mask = paddr == eqr_pkg::OFF_MASK;
  wire hit_errin = paddr == eqr_pkg::OFF_ERRIN;
  wire hit_active_function_query = paddr == eqr_pkg::OFF_ACTIVE_FUNCTION_QUERY;
  wire hit_serial = paddr == eqr_pkg::OFF_SERIAL;
  wire hit_nv = paddr == eqr_pkg::OFF_NVSTAT;
  wire hit_info = paddr == eqr_pkg::OFF_INFO;
  wire hit_text = paddr == eqr_pkg::OFF_TEXT;
  wire hit_any = hit_cmd || hit_resp || hit_stat || hit_mask || hit_errin
    || hit_active_function_query || hit_serial || hit_nv || hit_info || hit_text;
  // A new command while one runs is held off by pready low
  wire busy = state_reg != ST_IDLE;
  assign pready = !(hit_cmd && pwrite && busy);
  assign pslverr = acc && !hit_any;
  wire cmd_take = wr_acc && hit_cmd && !busy;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0] cmd_reg;          // Latched command word
  logic [31:0] resp_reg;         // Reply code word
  logic [1:0] text_idx_reg;      // Word of explain text to read
  logic [eqr_pkg::ST_WIDTH-1:0] stat_reg;
  logic [eqr_pkg::ST_WIDTH-1:0] mask_reg;
  logic [4:0] active_function_query_reg;          // Active function
  logic [31:0] serial_reg;       // Serial port settings
  logic [5:0] nv_reg;            // Restore state flags
  logic [DEPTH_LOG2:0] wptr_reg;
  logic [DEPTH_LOG2:0] rptr_reg;
  logic [CODE_W-1:0] text_code_reg;  // Code fed to the text table

  // ------------------------------------------------------------
  // Error queue
  // ------------------------------------------------------------
  localparam logic [DEPTH_LOG2:0] ONE = {{DEPTH_LOG2{1'b0}}, 1'b1};
  wire [DEPTH_LOG2:0] level = wptr_reg - rptr_reg;
  wire q_empty = level == '0;
  wire q_full = level[DEPTH_LOG2];
  wire err_in = wr_acc && hit_errin;
  // Only system errors, and only outside terminal mode
  wire err_sys = err_in && pwdata[eqr_pkg::ERR_SYS_BIT];
  wire q_push = err_sys && !term_mode && !q_full;
  wire q_drop = err_sys && !term_mode && q_full;
  wire term_msg = err_sys && term_mode;
  wire [3:0] op = cmd_reg[eqr_pkg::CMD_LSB +: 4];
  wire is_pop = op == eqr_pkg::CMD_POP
    || op == eqr_pkg::CMD_POP_EXPLAIN;
  // Pop happens in the exec step, and never in terminal mode
  wire q_pop = state_reg == ST_EXEC && is_pop && !q_empty
    && !term_mode;
  wire [CODE_W-1:0] head;

  eqr_fifo_mem #(.WIDTH(CODE_W), .AW(DEPTH_LOG2)) u_mem
  (
    .clk(clk),
    .wr_en(q_push),
    .wr_addr(wptr_reg[DEPTH_LOG2-1:0]),
    .wr_data(pwdata[CODE_W-1:0]),
    .rd_addr(rptr_reg[DEPTH_LOG2-1:0]),
    .rd_data(head)
  );

  // Pointer update; push and pop may share a cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end
    else
    begin
      if (q_push)
        wptr_reg <= wptr_reg + ONE;
      if (q_pop)
        rptr_reg <= rptr_reg + ONE;
    end
  end

  // ------------------------------------------------------------
  // Text table
  // ------------------------------------------------------------
  logic [31:0] text_word;
  eqr_text_rom u_rom
  (
    .clk(clk),
    .code(text_code_reg),
    .word_idx(text_idx_reg),
    .text(text_word)
  );

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  wire [1:0] sel = cmd_reg[eqr_pkg::SEL_LSB +: 2];
  wire [CODE_W-1:0] arg = cmd_reg[eqr_pkg::ARG_LSB +: CODE_W];
  wire is_restore = op == eqr_pkg::CMD_RESTORE;
  // Setup-only restore skips the protect switch
  wire restore_refused = is_restore && sel != eqr_pkg::SEL_SETUP
    && !cal_ok;
  wire bad_sel = is_restore && sel == 2'h3;
  wire do_cal = is_restore && !restore_refused
    && (sel == eqr_pkg::SEL_ALL || sel == eqr_pkg::SEL_CAL);
  wire do_setup = is_restore && !restore_refused
    && (sel == eqr_pkg::SEL_ALL || sel == eqr_pkg::SEL_SETUP);
  wire exec_err = state_reg == ST_EXEC
    && (restore_refused || bad_sel);
  wire done_pulse = state_reg == ST_FIN;
  // Popped code, or zero when empty or in terminal mode
  wire [CODE_W-1:0] pop_code = (q_empty || term_mode)
    ? eqr_pkg::NO_ERROR : head;

  // ------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------
  eqr_state_type state_next;
  assign state_next = (state_reg == ST_IDLE && cmd_take) ? ST_EXEC
    : (state_reg == ST_EXEC) ? ST_WAIT
    : (state_reg == ST_WAIT) ? ST_FIN
    : ST_IDLE;

  always_ff @(posedge clk)
  begin
    if (srst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Command latch and reply
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_reg <= '0;
      resp_reg <= '0;
      text_code_reg <= '0;
    end
    else if (cmd_take)
      cmd_reg <= pwdata;
    else if (state_reg == ST_EXEC)
    begin
      case (op)
        eqr_pkg::CMD_POP, eqr_pkg::CMD_POP_EXPLAIN:
        begin
          resp_reg <= {16'h0000, pop_code};
          text_code_reg <= pop_code;
        end
        eqr_pkg::CMD_EXPLAIN:
        begin
          resp_reg <= {16'h0000, arg};
          text_code_reg <= arg;
        end
        eqr_pkg::CMD_ACTIVE_FUNCTION_QUERY:
        begin
          resp_reg <= {27'h0, active_function_query_reg};
          text_code_reg <= {11'h008, active_function_query_reg};
        end
        default:
          resp_reg <= {31'h0, exec_err};
      endcase
    end
  end

  // ------------------------------------------------------------
  // Nonvolatile state, function and serial settings
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      nv_reg <= '0;
      serial_reg <= eqr_pkg::SER_DEFAULT;
      active_function_query_reg <= eqr_pkg::ACTIVE_FUNCTION_QUERY_RESET;
      mask_reg <= '0;
      text_idx_reg <= '0;
    end
    else
    begin
      nv_reg[eqr_pkg::NV_TERM] <= term_mode;
      if (state_reg == ST_EXEC && do_cal)
        nv_reg[eqr_pkg::NV_CAL_DEF] <= 1'b1;
      if (state_reg == ST_WAIT && do_setup)
      begin
        nv_reg[eqr_pkg::NV_SETUP_DEF] <= 1'b1;
        nv_reg[eqr_pkg::NV_PUD_CLR] <= 1'b1;
        nv_reg[eqr_pkg::NV_SRQ_DEF] <= 1'b1;
        nv_reg[eqr_pkg::NV_SPL_DEF] <= 1'b1;
        serial_reg <= eqr_pkg::SER_DEFAULT;
      end
      else if (wr_acc && hit_serial)
      begin
        serial_reg <= pwdata;
        nv_reg[eqr_pkg::NV_SETUP_DEF] <= 1'b0;
      end
      if (wr_acc && hit_active_function_query)
        active_function_query_reg <= pwdata[4:0];
      if (wr_acc && hit_mask)
        mask_reg <= pwdata[eqr_pkg::ST_WIDTH-1:0];
      if (wr_acc && hit_text)
        text_idx_reg <= pwdata[1:0];
    end
  end

  // ------------------------------------------------------------
  // Sticky status, cleared on read; a new event wins over the clear
  // ------------------------------------------------------------
  wire [eqr_pkg::ST_WIDTH-1:0] events =
    {term_msg, q_drop, q_push, exec_err, done_pulse};
  wire stat_rd = rd_acc && hit_stat;
  // Clear only the bits the read reported; a later event stays pending
  wire [eqr_pkg::ST_WIDTH-1:0] stat_clr = stat_rd
    ? prdata[eqr_pkg::ST_WIDTH-1:0] : '0;

  always_ff @(posedge clk)
  begin
    if (srst)
      stat_reg <= '0;
    else
      stat_reg <= (stat_reg & ~stat_clr) | events;
  end

  assign irq = |(stat_reg & mask_reg);

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  wire [31:0] rd_mux =
      hit_cmd ? cmd_reg
    : hit_resp ? resp_reg
    : hit_stat ? {27'h0, stat_reg}
    : hit_mask ? {27'h0, mask_reg}
    : hit_active_function_query ? {27'h0, active_function_query_reg}
    : hit_serial ? serial_reg
    : hit_nv ? {26'h0, nv_reg}
    : hit_info ? {15'h0, busy, {(16-DEPTH_LOG2-1){1'b0}}, level}
    : hit_text ? text_word
    : 32'h0;

  always_ff @(posedge clk)
  begin
    if (srst)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_refused;
    state_reg == ST_EXEC && restore_refused;
  endsequence

  a_empty_zero: assert property (@(posedge clk) disable iff (srst)
    state_reg == ST_EXEC && is_pop && q_empty |=> resp_reg[15:0] == 16'h0)
    else $error("Empty pop did not reply zero");

  a_refuse_err: assert property (@(posedge clk) disable iff (srst)
    s_refused |=> stat_reg[eqr_pkg::ST_EXEC_ERR])
    else $error("Refused restore raised no execution error");

  a_refuse_keep: assert property (@(posedge clk) disable iff (srst)
    s_refused |=> ##1 $stable(serial_reg))
    else $error("Refused restore changed setup");

  a_no_overfill: assert property (@(posedge clk) disable iff (srst)
    q_full |=> level <= (ONE << DEPTH_LOG2))
    else $error("Queue level beyond depth");

  a_pop_step: assert property (@(posedge clk) disable iff (srst)
    q_pop && !q_push |=> level == $past(level) - ONE)
    else $error("Pop did not remove one entry");

  a_term_noq: assert property (@(posedge clk) disable iff (srst)
    term_mode && err_in |=> level == $past(level))
    else $error("Terminal mode queued an error");

  a_setup_serial: assert property (@(posedge clk) disable iff (srst)
    state_reg == ST_WAIT && do_setup |=> serial_reg == eqr_pkg::SER_DEFAULT)
    else $error("Setup restore left serial settings");

  a_one_cmd: assert property (@(posedge clk) disable iff (srst)
    cmd_take |=> state_reg == ST_EXEC ##1 state_reg == ST_WAIT
      ##1 state_reg == ST_FIN ##1 state_reg == ST_IDLE)
    else $error("Command sequence broken");

endmodule : eqr_core
`default_nettype wire

// *** sim/eqr_host_model.sv ***
/*
  Host model: an APB master standing in for the remote controller.
  Assumes the bench calls xfer, one transfer at a time, on clk.
*/
`timescale 1ns/100ps
`default_nettype none

module eqr_host_model
(
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ----------------------------------------------------------------
  // Logged read results, watched by the bench monitor
  // ----------------------------------------------------------------
  int rd_cnt = 0;         // Bumped once per logged read
  logic [32:0] rd_q;      // Error flag and read data

  // Bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One transfer; the request stays put until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input bit log, output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    if (log)
    begin
      rd_q = {pslverr, prdata};
      rd_cnt++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : eqr_host_model
`default_nettype wire

// *** sim/error_queue_and_nvm_restore_commands_bench.sv ***
/*
  Self-checking bench for the error queue and restore block.
  Assumes eqr_core with default queue depth of 8 and the host model.
*/
`timescale 1ns/100ps
`default_nettype none

module error_queue_and_nvm_restore_commands_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cal_enable_pin = 1'b0;   // Protect switch starts disabled
  logic term_mode_pin = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] codes [9];        // Codes pushed, in arrival order
  logic [32:0] expq [$];         // Expected read notes, oldest first
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  eqr_core uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cal_enable_pin(cal_enable_pin),
    .term_mode_pin(term_mode_pin), .irq(irq));

  eqr_host_model host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // ----------------------------------------------------------------
  // Compare, close, and bus helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    if (expq.size() != 0)
      fail_count++;
    $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, 1'b0, q);
  endtask : wr

  // Note the expectation, then read; the monitor compares
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    host.xfer(1'b0, a, 32'h0, 1'b1, q);
  endtask : rd

  // Issue a command and poll busy; the timeout bounds the wait
  task automatic cmd(input logic [31:0] d);
    wr(8'h00, d);
    do host.xfer(1'b0, 8'h20, 32'h0, 1'b0, q); while (q[16] !== 1'b0);
  endtask : cmd

  function automatic logic [31:0] rs(input logic [1:0] s);
    return {22'h0, s, 8'h04};
  endfunction : rs

  // Monitor: each logged read takes the oldest note
  always @(host.rd_cnt) check(host.rd_q, expq.pop_front());

  // Hang guard: a stuck wait ends the run as a failure
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(91632));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(8'h18, {1'b0, eqr_pkg::SER_DEFAULT});
    rd(8'h40, 33'h1_0000_0000);
    wr(8'h0c, 32'h4);
    wr(8'h10, 32'h0000_1234);
    rd(8'h20, 33'h0);
    for (int i = 0; i < 9; i++)
    begin
      codes[i] = 16'h1 + 16'($urandom_range(32'hfff0));
      wr(8'h10, {15'h0, 1'b1, codes[i]});
    end
    check({32'h0, irq}, 33'h1);
    rd(8'h08, 33'hc);
    @(posedge clk);
    check({32'h0, irq}, 33'h0);
    rd(8'h20, 33'h8);
    for (int i = 0; i < 8; i++)
    begin
      cmd(32'h1);
      rd(8'h04, {17'h0, codes[i]});
    end
    check({32'h0, irq}, 33'h0);
    cmd(32'h1);
    rd(8'h04, 33'h0);
    cmd(32'h3);
    rd(8'h04, 33'h0);
    wr(8'h24, 32'h0);
    rd(8'h24, 33'h4e6f2045);
    cmd({16'hffff, 16'h0002});
    wr(8'h24, 32'h0);
    rd(8'h24, 33'h3f3f3f3f);
    cmd({16'h0001, 16'h0002});
    wr(8'h24, 32'h1);
    rd(8'h24, {1'b0, eqr_pkg::CH_PCT, eqr_pkg::CH_D, 16'h2020});
    wr(8'h14, 32'(eqr_pkg::ACTIVE_FUNCTION_QUERY_DUAL_DCV));
    cmd(32'h5);
    rd(8'h04, 33'(eqr_pkg::ACTIVE_FUNCTION_QUERY_DUAL_DCV));
    wr(8'h24, 32'h0);
    rd(8'h24, 33'h44434444);
    wr(8'h18, 32'h0);
    cmd(rs(eqr_pkg::SEL_CAL));
    rd(8'h08, 33'h3);
    rd(8'h04, 33'h1);
    rd(8'h18, 33'h0);
    cmd(rs(eqr_pkg::SEL_SETUP));
    rd(8'h18, {1'b0, eqr_pkg::SER_DEFAULT});
    rd(8'h1c, 33'h1e);
    cal_enable_pin <= 1'b1;
    repeat (3) @(posedge clk);
    wr(8'h08, 32'h0);
    rd(8'h08, 33'h1);
    cmd(rs(eqr_pkg::SEL_ALL));
    rd(8'h1c, 33'h1f);
    rd(8'h08, 33'h1);
    cmd(rs(2'h3));
    rd(8'h08, 33'h3);
    term_mode_pin <= 1'b1;
    repeat (3) @(posedge clk);
    wr(8'h10, 32'h0001_0042);
    rd(8'h20, 33'h0);
    rd(8'h08, 33'h10);
    cmd(32'h3);
    rd(8'h04, 33'h0);
    // Mid-run reset must bring the serial settings back to default
    wr(8'h18, 32'h0);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(8'h18, {1'b0, eqr_pkg::SER_DEFAULT});
    // Let the monitor take the last note before closing
    @(posedge clk);
    test_done();
  end
endmodule : error_queue_and_nvm_restore_commands_bench
`default_nettype wire
